// ---- verilog/vips_defines.svh ----
// Offsets, field positions, reset values and sizes of the sequencer
`ifndef VIPS_DEFINES_SVH
`define VIPS_DEFINES_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define VIPS_ADDR_W 12
`define VIPS_OFF_SVR_BASE 12'h080
`define VIPS_SVR_SEL_LSB 7
`define VIPS_OFF_NORMAL_VEC 12'h100
`define VIPS_OFF_FAST_VEC 12'h104
`define VIPS_OFF_CUR_ID 12'h108
`define VIPS_OFF_PENDING 12'h10C
`define VIPS_OFF_LINES 12'h114
`define VIPS_OFF_SET_PENDING 12'h12C
`define VIPS_OFF_END_HANDLING 12'h130
`define VIPS_OFF_SPURIOUS 12'h134

// ****************************************************************
// Source bit positions
// ****************************************************************
`define VIPS_BIT_FAST 0
`define VIPS_BIT_SOFTWARE 1
`define VIPS_BIT_SERIAL0 2
`define VIPS_BIT_SERIAL1 3
`define VIPS_BIT_TIMER0 4
`define VIPS_BIT_TIMER1 5
`define VIPS_BIT_TIMER2 6
`define VIPS_BIT_WATCHDOG 7
`define VIPS_BIT_PARALLEL_IO 8
`define VIPS_BIT_EXTERNAL0 16
`define VIPS_BIT_EXTERNAL1 17
`define VIPS_BIT_EXTERNAL2 18
`define VIPS_SRC_MASK 32'h0007_01FF
`define VIPS_NORMAL_MASK 32'h0007_01FE

// ****************************************************************
// Line status bits and reset values
// ****************************************************************
`define VIPS_LINE_FAST_BIT 0
`define VIPS_LINE_NORMAL_BIT 1
`define VIPS_SPURIOUS_RST 32'h0000_0000
`define VIPS_DATA_ZERO 32'h0000_0000

`endif

// ---- verilog/vips_pkg.sv ----
// State type used by the core end of the sequencer link
package vips_pkg;
	typedef enum logic [2:0] {
		CORE_IDLE,
		CORE_VEC_WAIT,
		CORE_IRQ_RUN,
		CORE_FIQ_RUN,
		CORE_CMD_WAIT
	} vips_core_state_t;
endpackage

// ---- verilog/vips_if.sv ----
// Register access and request lines between controller and core
`timescale 1ns/1ns
interface vips_if;
	logic [11:0] bus_addr;
	logic bus_rd;
	logic bus_wr;
	logic [31:0] bus_wdata;
	logic [31:0] bus_rdata;
	logic bus_rvalid;
	logic normal_request_line;
	logic fast_request_line;

	modport dev (
		input bus_addr,
		input bus_rd,
		input bus_wr,
		input bus_wdata,
		output bus_rdata,
		output bus_rvalid,
		output normal_request_line,
		output fast_request_line
	);

	modport core (
		output bus_addr,
		output bus_rd,
		output bus_wr,
		output bus_wdata,
		input bus_rdata,
		input bus_rvalid,
		input normal_request_line,
		input fast_request_line
	);
endinterface

// ---- verilog/vips_prio_pick.sv ----
// Finds the pending request with the highest priority level
`timescale 1ns/1ns
module vips_prio_pick #(
	parameter int NSRC = 32,
	parameter int PRIO_W = 3
) (
	input wire logic [NSRC-1:0] req,
	input wire logic [NSRC*PRIO_W-1:0] prio,
	output logic found,
	output logic [$clog2(NSRC)-1:0] idx,
	output logic [PRIO_W-1:0] level
);
	// Scan downward so that equal levels favour the lower source number
	always_comb begin
		found = 1'b0;
		idx = '0;
		level = '0;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (req[i] && (!found || prio[i*PRIO_W +: PRIO_W] >= level)) begin
				found = 1'b1;
				idx = i[$clog2(NSRC)-1:0];
				level = prio[i*PRIO_W +: PRIO_W];
			end
		end
	end
endmodule

// ---- verilog/vips_ctrl.sv ----
// Controller end: vectoring, level stack and request lines
`timescale 1ns/1ns
`include "vips_defines.svh"
module vips_ctrl #(
	parameter int NSRC = 32,
	parameter int PRIO_W = 3,
	parameter int DEPTH = 2 ** PRIO_W
) (
	input wire logic clk,
	input wire logic rst_b,
	vips_if.dev link,
	input wire logic [NSRC-1:0] src_in,
	input wire logic [NSRC-1:0] src_edge,
	input wire logic [NSRC-1:0] src_enable,
	input wire logic [NSRC*PRIO_W-1:0] src_prio,
	output logic [$clog2(NSRC)-1:0] cur_id,
	output logic cur_active
);
	localparam int IW = $clog2(NSRC);
	localparam int SW = $clog2(DEPTH + 1);

	// ****************************************************************
	// State
	// ****************************************************************
	logic [NSRC-1:0] pend_reg, pend_next;
	logic [NSRC-1:0] prev_reg, prev_next;
	logic [31:0] svr_reg [NSRC];
	logic [31:0] svr_next [NSRC];
	logic [31:0] spu_reg, spu_next;
	logic [IW-1:0] cur_id_reg, cur_id_next;
	logic [PRIO_W-1:0] cur_lvl_reg, cur_lvl_next;
	logic cur_val_reg, cur_val_next;
	logic [IW-1:0] stk_id_reg [DEPTH];
	logic [IW-1:0] stk_id_next [DEPTH];
	logic [PRIO_W-1:0] stk_lvl_reg [DEPTH];
	logic [PRIO_W-1:0] stk_lvl_next [DEPTH];
	logic [SW-1:0] sp_reg, sp_next;
	logic nrm_reg, nrm_next;
	logic fst_reg, fst_next;
	logic [31:0] rdata_reg, rdata_next;
	logic rvalid_reg, rvalid_next;

	// ****************************************************************
	// Decode and priority search
	// ****************************************************************
	logic rd_nvec, rd_fvec, wr_set, wr_eoh, wr_spu, svr_hit;
	logic [IW-1:0] svr_idx;
	logic best_found;
	logic [IW-1:0] best_idx;
	logic [PRIO_W-1:0] best_lvl;
	logic [NSRC-1:0] cand;

	assign rd_nvec = link.bus_rd && link.bus_addr == `VIPS_OFF_NORMAL_VEC;
	assign rd_fvec = link.bus_rd && link.bus_addr == `VIPS_OFF_FAST_VEC;
	assign wr_set = link.bus_wr && link.bus_addr == `VIPS_OFF_SET_PENDING;
	assign wr_eoh = link.bus_wr &&
		link.bus_addr == `VIPS_OFF_END_HANDLING;
	assign wr_spu = link.bus_wr && link.bus_addr == `VIPS_OFF_SPURIOUS;
	assign svr_hit = link.bus_addr[11:`VIPS_SVR_SEL_LSB] ==
		5'(`VIPS_OFF_SVR_BASE >> `VIPS_SVR_SEL_LSB);
	assign svr_idx = link.bus_addr[IW+1:2];
	assign cand = pend_reg & src_enable & NSRC'(`VIPS_NORMAL_MASK);

	vips_prio_pick #(
		.NSRC(NSRC),
		.PRIO_W(PRIO_W)
	) u_pick (
		.req(cand),
		.prio(src_prio),
		.found(best_found),
		.idx(best_idx),
		.level(best_lvl)
	);

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		logic [NSRC-1:0] clr;
		logic [NSRC-1:0] rise;
		clr = '0;
		rise = src_in & ~prev_reg;
		prev_next = src_in;
		cur_id_next = cur_id_reg;
		cur_lvl_next = cur_lvl_reg;
		cur_val_next = cur_val_reg;
		stk_id_next = stk_id_reg;
		stk_lvl_next = stk_lvl_reg;
		sp_next = sp_reg;
		spu_next = wr_spu ? link.bus_wdata : spu_reg;
		svr_next = svr_reg;
		if (link.bus_wr && svr_hit) begin
			svr_next[svr_idx] = link.bus_wdata;
		end
		rdata_next = `VIPS_DATA_ZERO;
		rvalid_next = link.bus_rd;
		if (rd_nvec) begin
			if (best_found) begin
				if (cur_val_reg && sp_reg < SW'(DEPTH)) begin
					stk_id_next[sp_reg[SW-2:0]] = cur_id_reg;
					stk_lvl_next[sp_reg[SW-2:0]] = cur_lvl_reg;
					sp_next = sp_reg + SW'(1);
				end
				cur_id_next = best_idx;
				cur_lvl_next = best_lvl;
				cur_val_next = 1'b1;
				clr[best_idx] = src_edge[best_idx];
				rdata_next = svr_reg[best_idx];
			end else if (cur_val_reg) begin
				rdata_next = spu_reg;
			end else begin
				rdata_next = `VIPS_DATA_ZERO;
			end
		end else if (wr_eoh) begin
			if (sp_reg != '0) begin
				cur_id_next = stk_id_reg[sp_reg[SW-2:0] - 1'b1];
				cur_lvl_next = stk_lvl_reg[sp_reg[SW-2:0] - 1'b1];
				sp_next = sp_reg - SW'(1);
			end else begin
				cur_val_next = 1'b0;
			end
		end
		if (rd_fvec) begin
			clr[`VIPS_BIT_FAST] = src_edge[`VIPS_BIT_FAST];
			rdata_next = svr_reg[`VIPS_BIT_FAST];
		end else if (link.bus_rd && svr_hit) begin
			rdata_next = svr_reg[svr_idx];
		end else if (link.bus_rd) begin
			unique case (link.bus_addr)
				`VIPS_OFF_CUR_ID: rdata_next = 32'(cur_id_reg);
				`VIPS_OFF_PENDING: rdata_next = 32'(pend_reg);
				`VIPS_OFF_SPURIOUS: rdata_next = spu_reg;
				`VIPS_OFF_LINES: begin
					rdata_next[`VIPS_LINE_FAST_BIT] = fst_reg;
					rdata_next[`VIPS_LINE_NORMAL_BIT] = nrm_reg;
				end
				default: rdata_next = rd_nvec ? rdata_next :
					`VIPS_DATA_ZERO;
			endcase
		end
		// Set wins over an automatic clear in the same cycle
		pend_next = (pend_reg & ~clr) | (rise & src_edge);
		pend_next = (pend_next & src_edge) | (src_in & ~src_edge);
		if (wr_set) begin
			pend_next = pend_next |
				(link.bus_wdata[NSRC-1:0] & NSRC'(`VIPS_SRC_MASK));
		end
		fst_next = pend_next[`VIPS_BIT_FAST] &
			src_enable[`VIPS_BIT_FAST];
		if (rd_nvec) begin
			nrm_next = 1'b0;
		end else begin
			// Covers nesting and the reassert after a pop
			nrm_next = best_found &&
				(!cur_val_next || best_lvl > cur_lvl_next);
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pend_reg <= '0;
			prev_reg <= '0;
			spu_reg <= `VIPS_SPURIOUS_RST;
			cur_id_reg <= '0;
			cur_lvl_reg <= '0;
			cur_val_reg <= 1'b0;
			sp_reg <= '0;
			nrm_reg <= 1'b0;
			fst_reg <= 1'b0;
			rdata_reg <= `VIPS_DATA_ZERO;
			rvalid_reg <= 1'b0;
			for (int i = 0; i < NSRC; i++) begin
				svr_reg[i] <= `VIPS_DATA_ZERO;
			end
			for (int i = 0; i < DEPTH; i++) begin
				stk_id_reg[i] <= '0;
				stk_lvl_reg[i] <= '0;
			end
		end else begin
			pend_reg <= pend_next;
			prev_reg <= prev_next;
			spu_reg <= spu_next;
			cur_id_reg <= cur_id_next;
			cur_lvl_reg <= cur_lvl_next;
			cur_val_reg <= cur_val_next;
			sp_reg <= sp_next;
			nrm_reg <= nrm_next;
			fst_reg <= fst_next;
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
			svr_reg <= svr_next;
			stk_id_reg <= stk_id_next;
			stk_lvl_reg <= stk_lvl_next;
		end
	end

	assign link.bus_rdata = rdata_reg;
	assign link.bus_rvalid = rvalid_reg;
	assign link.normal_request_line = nrm_reg;
	assign link.fast_request_line = fst_reg;
	assign cur_id = cur_id_reg;
	assign cur_active = cur_val_reg;
endmodule

// ---- verilog/vips_core.sv ----
// Core end: takes requests, fetches vectors, closes handling
`timescale 1ns/1ns
`include "vips_defines.svh"
module vips_core (
	input wire logic clk,
	input wire logic rst_b,
	vips_if.core link,
	input wire logic irq_mask,
	input wire logic fiq_mask,
	input wire logic handler_done,
	input wire logic cmd_rd,
	input wire logic cmd_wr,
	input wire logic [11:0] cmd_addr,
	input wire logic [31:0] cmd_wdata,
	output logic [31:0] cmd_rdata,
	output logic cmd_rvalid,
	output logic cmd_busy,
	output logic pc_load,
	output logic [31:0] pc_addr,
	output logic in_irq,
	output logic in_fiq
);
	// ****************************************************************
	// State
	// ****************************************************************
	vips_pkg::vips_core_state_t st_reg, st_next;
	logic fast_reg, fast_next;
	logic [11:0] addr_reg, addr_next;
	logic rd_reg, rd_next;
	logic wr_reg, wr_next;
	logic [31:0] wdata_reg, wdata_next;
	logic [31:0] crd_reg, crd_next;
	logic crv_reg, crv_next;
	logic pcl_reg, pcl_next;
	logic [31:0] pca_reg, pca_next;

	always_comb begin
		st_next = st_reg;
		fast_next = fast_reg;
		addr_next = addr_reg;
		rd_next = 1'b0;
		wr_next = 1'b0;
		wdata_next = wdata_reg;
		crd_next = crd_reg;
		crv_next = 1'b0;
		pcl_next = 1'b0;
		pca_next = pca_reg;
		unique case (st_reg)
			vips_pkg::CORE_IDLE: begin
				if (link.fast_request_line && !fiq_mask) begin
					addr_next = `VIPS_OFF_FAST_VEC;
					rd_next = 1'b1;
					fast_next = 1'b1;
					st_next = vips_pkg::CORE_VEC_WAIT;
				end else if (link.normal_request_line && !irq_mask) begin
					addr_next = `VIPS_OFF_NORMAL_VEC;
					rd_next = 1'b1;
					fast_next = 1'b0;
					st_next = vips_pkg::CORE_VEC_WAIT;
				end else if (cmd_rd || cmd_wr) begin
					addr_next = cmd_addr;
					rd_next = cmd_rd;
					wr_next = cmd_wr && !cmd_rd;
					wdata_next = cmd_wdata;
					st_next = cmd_rd ? vips_pkg::CORE_CMD_WAIT :
						vips_pkg::CORE_IDLE;
				end
			end
			vips_pkg::CORE_VEC_WAIT: begin
				if (link.bus_rvalid) begin
					pcl_next = 1'b1;
					pca_next = link.bus_rdata;
					st_next = fast_reg ? vips_pkg::CORE_FIQ_RUN :
						vips_pkg::CORE_IRQ_RUN;
				end
			end
			vips_pkg::CORE_IRQ_RUN: begin
				// Handler cleared level sources before done
				if (handler_done) begin
					addr_next = `VIPS_OFF_END_HANDLING;
					wr_next = 1'b1;
					st_next = vips_pkg::CORE_IDLE;
				end
			end
			vips_pkg::CORE_FIQ_RUN: begin
				if (handler_done) begin
					st_next = vips_pkg::CORE_IDLE;
				end
			end
			vips_pkg::CORE_CMD_WAIT: begin
				if (link.bus_rvalid) begin
					crd_next = link.bus_rdata;
					crv_next = 1'b1;
					st_next = vips_pkg::CORE_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_reg <= vips_pkg::CORE_IDLE;
			fast_reg <= 1'b0;
			addr_reg <= '0;
			rd_reg <= 1'b0;
			wr_reg <= 1'b0;
			wdata_reg <= `VIPS_DATA_ZERO;
			crd_reg <= `VIPS_DATA_ZERO;
			crv_reg <= 1'b0;
			pcl_reg <= 1'b0;
			pca_reg <= `VIPS_DATA_ZERO;
		end else begin
			st_reg <= st_next;
			fast_reg <= fast_next;
			addr_reg <= addr_next;
			rd_reg <= rd_next;
			wr_reg <= wr_next;
			wdata_reg <= wdata_next;
			crd_reg <= crd_next;
			crv_reg <= crv_next;
			pcl_reg <= pcl_next;
			pca_reg <= pca_next;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	logic irq_run_reg, fiq_run_reg, busy_reg;
	logic irq_run_next, fiq_run_next, busy_next;
	always_comb begin
		irq_run_next = st_next == vips_pkg::CORE_IRQ_RUN;
		fiq_run_next = st_next == vips_pkg::CORE_FIQ_RUN;
		busy_next = st_next != vips_pkg::CORE_IDLE;
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_run_reg <= 1'b0;
			fiq_run_reg <= 1'b0;
			busy_reg <= 1'b0;
		end else begin
			irq_run_reg <= irq_run_next;
			fiq_run_reg <= fiq_run_next;
			busy_reg <= busy_next;
		end
	end

	assign link.bus_addr = addr_reg;
	assign link.bus_rd = rd_reg;
	assign link.bus_wr = wr_reg;
	assign link.bus_wdata = wdata_reg;
	assign cmd_rdata = crd_reg;
	assign cmd_rvalid = crv_reg;
	assign cmd_busy = busy_reg;
	assign pc_load = pcl_reg;
	assign pc_addr = pca_reg;
	assign in_irq = irq_run_reg;
	assign in_fiq = fiq_run_reg;
endmodule

// ---- tb/vips_assertions.sv ----
// Interface checks between the controller and core ends
`timescale 1ns/1ns
module vips_assertions (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [11:0] bus_addr,
	input wire logic bus_rd,
	input wire logic bus_wr,
	input wire logic [31:0] bus_wdata,
	input wire logic [31:0] bus_rdata,
	input wire logic bus_rvalid,
	input wire logic normal_request_line,
	input wire logic fast_request_line
);
	logic [31:0] spu_reg;
	logic [31:0] spu_next;
	logic [31:0] fvec_reg;
	logic [31:0] fvec_next;

	// Shadows of the spurious address and vector entry zero
	always_comb begin
		spu_next = spu_reg;
		fvec_next = fvec_reg;
		if (bus_wr && bus_addr == 12'h134)
			spu_next = bus_wdata;
		if (bus_wr && bus_addr == 12'h080)
			fvec_next = bus_wdata;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			spu_reg <= 32'h0000_0000;
			fvec_reg <= 32'h0000_0000;
		end else begin
			spu_reg <= spu_next;
			fvec_reg <= fvec_next;
		end
	end

	// ****************************************
	// Properties
	// ****************************************
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	property p_rd_answer;
		bus_rd |=> bus_rvalid;
	endproperty
	a_rd_answer: assert property (p_rd_answer)
		else $error("read not answered");
	property p_no_answer;
		!bus_rd |=> !bus_rvalid;
	endproperty
	a_no_answer: assert property (p_no_answer)
		else $error("answer without read");
	property p_vec_drop;
		bus_rd && bus_addr == 12'h100 |-> ##1 !normal_request_line;
	endproperty
	a_vec_drop: assert property (p_vec_drop)
		else $error("normal line kept after vector read");
	property p_spu;
		bus_rd && bus_addr == 12'h134 |=> bus_rdata == $past(spu_reg);
	endproperty
	a_spu: assert property (p_spu)
		else $error("spurious address readback wrong");
	property p_fast_vec;
		bus_rd && bus_addr == 12'h104 |=> bus_rdata == $past(fvec_reg);
	endproperty
	a_fast_vec: assert property (p_fast_vec)
		else $error("fast vector wrong");
	property p_unmapped;
		bus_rd && bus_addr < 12'h080 |=> bus_rdata == 32'h0000_0000;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	property p_set_fast;
		bus_wr && bus_addr == 12'h12C && bus_wdata[0] |-> ##2
			fast_request_line;
	endproperty
	a_set_fast: assert property (p_set_fast)
		else $error("fast line not raised by set");
	property p_lines;
		bus_rd && bus_addr == 12'h114 |=> bus_rdata[1] ==
			$past(normal_request_line) && bus_rdata[0] ==
			$past(fast_request_line);
	endproperty
	a_lines: assert property (p_lines)
		else $error("line status wrong");

	c_vec: cover property (bus_rd && bus_addr == 12'h100 &&
		normal_request_line);
	c_end: cover property (bus_wr && bus_addr == 12'h130);
	c_fast: cover property (bus_rd && bus_addr == 12'h104 &&
		fast_request_line);
endmodule

// ---- tb/tb.sv ----
// Bench joining controller and core ends of the sequencer
`timescale 1ns/1ns
module tb;
	logic clk;
	logic rst_b;
	logic [31:0] src_in, src_edge, src_en, rd;
	logic [95:0] prio;
	logic [4:0] cur_id;
	logic cur_act, irq_m, fiq_m, done, c_rd, c_wr, c_rv, busy, pcl;
	logic in_irq, in_fiq;
	logic [11:0] c_a;
	logic [31:0] c_wd, c_rdat, pc;
	logic [31:0] vec [32];
	logic [95:0] pr;
	int bad_count, n_tests, seed, cyc, n;
	int srcs [12] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 16, 17, 18};

	vips_if lk ();
	vips_ctrl vips_ctrl_inst (.clk(clk), .rst_b(rst_b), .link(lk.dev),
		.src_in(src_in), .src_edge(src_edge), .src_enable(src_en),
		.src_prio(prio), .cur_id(cur_id), .cur_active(cur_act));
	vips_core vips_core_inst (.clk(clk), .rst_b(rst_b), .link(lk.core),
		.irq_mask(irq_m), .fiq_mask(fiq_m), .handler_done(done),
		.cmd_rd(c_rd), .cmd_wr(c_wr), .cmd_addr(c_a), .cmd_wdata(c_wd),
		.cmd_rdata(c_rdat), .cmd_rvalid(c_rv), .cmd_busy(busy),
		.pc_load(pcl), .pc_addr(pc), .in_irq(in_irq), .in_fiq(in_fiq));
	vips_assertions vips_assertions_inst (.clk(clk), .rst_b(rst_b),
		.bus_addr(lk.bus_addr), .bus_rd(lk.bus_rd), .bus_wr(lk.bus_wr),
		.bus_wdata(lk.bus_wdata), .bus_rdata(lk.bus_rdata),
		.bus_rvalid(lk.bus_rvalid),
		.normal_request_line(lk.normal_request_line),
		.fast_request_line(lk.fast_request_line));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] bitv(input int b);
		return 32'h0000_0001 << b;
	endfunction

	function automatic logic [11:0] vaddr(input int e);
		return 12'h080 + 12'(e * 4);
	endfunction

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// One command through the core; reads leave the answer in rd
	task automatic acc(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		int k;
		k = 0;
		while (busy !== 1'b0 && k < 40) begin
			@(posedge clk);
			k++;
		end
		c_wr <= wr;
		c_rd <= !wr;
		c_a <= a;
		c_wd <= d;
		@(posedge clk);
		c_wr <= 1'b0;
		c_rd <= 1'b0;
		k = 0;
		while (!wr && c_rv !== 1'b1 && k < 40) begin
			@(posedge clk);
			k++;
		end
		rd = c_rdat;
		if (wr)
			repeat (3) @(posedge clk);
	endtask

	task automatic wait_pc();
		int k;
		k = 0;
		while (pcl !== 1'b1 && k < 30) begin
			@(posedge clk);
			k++;
		end
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 6000) begin
			bad_count++;
			test_done();
		end
	end

	initial begin
		rst_b = 1'b0;
		src_in = '0;
		src_edge = '1;
		src_en = '1;
		prio = {32{3'h1}};
		irq_m = 1'b1;
		fiq_m = 1'b1;
		done = 1'b0;
		c_rd = 1'b0;
		c_wr = 1'b0;
		c_a = '0;
		c_wd = '0;
		seed = 87;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		acc(0, 12'h134, '0);
		chk("spu_rst", rd, '0);
		acc(0, 12'h100, '0);
		chk("vec_idle", rd, '0);
		acc(0, 12'h000, '0);
		chk("unmapped", rd, '0);
		$display("test reset done");
		for (int i = 0; i < 32; i++) begin
			vec[i] = $random(seed);
			acc(1, vaddr(i), vec[i]);
			acc(0, vaddr(i), '0);
			chk("table", rd, vec[i]);
		end
		vec[1] = $random(seed);
		acc(1, 12'h134, vec[1]);
		acc(0, 12'h134, '0);
		chk("spu", rd, vec[1]);
		acc(1, vaddr(1), vec[1]);
		acc(1, 12'h12C, 32'hFFF8_FE00);
		acc(0, 12'h10C, '0);
		chk("reserved", rd, '0);
		foreach (srcs[k]) begin
			acc(1, 12'h12C, bitv(srcs[k]));
			acc(0, 12'h10C, '0);
			chk("pend", rd, bitv(srcs[k]));
			acc(0, srcs[k] == 0 ? 12'h104 : 12'h100, '0);
			chk("vec", rd, vec[srcs[k]]);
			acc(0, 12'h10C, '0);
			chk("cleared", rd, '0);
			acc(0, 12'h114, '0);
			chk("lines", rd, '0);
			if (srcs[k] != 0) begin
				chk("cur", {27'h0, cur_id}, 32'(srcs[k]));
				acc(1, 12'h130, $random(seed));
				chk("ended", {31'h0, cur_act}, '0);
			end
		end
		$display("test sources done");
		prio[12 +: 3] <= 3'h2;
		prio[15 +: 3] <= 3'h4;
		prio[48 +: 3] <= 3'h6;
		acc(1, 12'h12C, bitv(4));
		acc(0, 12'h100, '0);
		acc(1, 12'h12C, bitv(16));
		repeat (2) @(posedge clk);
		chk("nest_up", {31'h0, lk.normal_request_line}, 1);
		acc(0, 12'h100, '0);
		chk("nest_vec", rd, vec[16]);
		acc(1, 12'h12C, bitv(5));
		repeat (2) @(posedge clk);
		chk("nest_low", {31'h0, lk.normal_request_line}, '0);
		acc(1, 12'h130, '0);
		chk("pop", {27'h0, cur_id}, 4);
		chk("reassert", {31'h0, lk.normal_request_line}, 1);
		acc(0, 12'h100, '0);
		chk("vec5", rd, vec[5]);
		acc(1, 12'h130, '0);
		acc(1, 12'h130, '0);
		chk("empty", {31'h0, cur_act}, '0);
		$display("test nesting done");
		pr = {32{3'h1}};
		for (int i = 0; i < 8; i++) begin
			pr[srcs[i + 1] * 3 +: 3] = 3'(i);
		end
		prio <= pr;
		for (int i = 0; i < 8; i++) begin
			acc(1, 12'h12C, bitv(srcs[i + 1]));
			acc(0, 12'h100, '0);
			chk("deep_vec", rd, vec[srcs[i + 1]]);
		end
		for (int i = 7; i >= 0; i--) begin
			acc(0, 12'h108, '0);
			chk("deep_cur", rd, 32'(srcs[i + 1]));
			acc(1, 12'h130, '0);
		end
		chk("deep_end", {31'h0, cur_act}, '0);
		$display("test depth done");
		src_edge[7] <= 1'b0;
		src_in[7] <= 1'b1;
		acc(0, 12'h100, '0);
		chk("lvl_vec", rd, vec[7]);
		acc(0, 12'h10C, '0);
		chk("lvl_kept", rd, bitv(7));
		src_in[7] <= 1'b0;
		acc(1, 12'h130, '0);
		src_edge[0] <= 1'b0;
		src_in[0] <= 1'b1;
		acc(0, 12'h104, '0);
		acc(0, 12'h114, '0);
		chk("fast_lvl", rd, 1);
		src_in[0] <= 1'b0;
		repeat (3) @(posedge clk);
		chk("fast_off", {31'h0, lk.fast_request_line}, '0);
		$display("test level done");
		n = srcs[1 + ($unsigned($random(seed)) % 11)];
		src_edge <= '1;
		irq_m <= 1'b0;
		src_in[n] <= 1'b1;
		wait_pc();
		chk("pc", pc, vec[n]);
		chk("in_irq", {31'h0, in_irq}, 1);
		src_in[n] <= 1'b0;
		done <= 1'b1;
		@(posedge clk);
		done <= 1'b0;
		repeat (4) @(posedge clk);
		chk("auto_end", {30'h0, cur_act, in_irq}, '0);
		fiq_m <= 1'b0;
		src_in[0] <= 1'b1;
		wait_pc();
		chk("pc_fast", pc, vec[0]);
		chk("in_fiq", {31'h0, in_fiq}, 1);
		repeat (2) @(posedge clk);
		chk("fast_drop", {31'h0, lk.fast_request_line}, '0);
		$display("test core done");
		test_done();
	end
endmodule
